// *** tmr3_pkg.sv ***
// constants shared by the timer three counter, its clock mux and its edge tickers
package tmr3_pkg;

	// ----------------------------------------------------------------
	// special function register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL     = 8'h91;
	localparam logic [7:0] ADDR_RELOAD_LOW  = 8'h92;
	localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
	localparam logic [7:0] ADDR_COUNT_LOW   = 8'h94;
	localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h95;

	// ----------------------------------------------------------------
	// control register field positions
	// ----------------------------------------------------------------
	localparam int BIT_HIGH_FLAG   = 7;
	localparam int BIT_LOW_FLAG    = 6;
	localparam int BIT_LOW_IRQ_EN  = 5;
	localparam int BIT_CAPTURE_EN  = 4;
	localparam int BIT_SPLIT       = 3;
	localparam int BIT_RUN         = 2;
	localparam int BIT_ALT_SEL_HI  = 1;
	localparam int BIT_ALT_SEL_LO  = 0;

	// ----------------------------------------------------------------
	// reset values and counter limits
	// ----------------------------------------------------------------
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET    = 8'h00;
	localparam logic [7:0] BYTE_MAX      = 8'hFF;
	localparam logic [7:0] BYTE_ZERO     = 8'h00;

	// ----------------------------------------------------------------
	// clock dividers
	// ----------------------------------------------------------------
	localparam int SYSTEM_CLOCK_DIV = 12;
	localparam int EXT_DIV    = 8;
	localparam int RTC_DIV    = 1;

	// ----------------------------------------------------------------
	// alternate clock select codes
	// ----------------------------------------------------------------
	localparam logic [1:0] ALT_SYSTEM_CLOCK_DIV12 = 2'h0;
	localparam logic [1:0] ALT_RTC          = 2'h1;
	localparam logic [1:0] ALT_RESERVED     = 2'h2;
	localparam logic [1:0] ALT_EXT_DIV8     = 2'h3;

endpackage : tmr3_pkg

// *** tmr3_edge_tick.sv ***
// synchroniser and rising-edge divider for a slow asynchronous clock source
`timescale 1ns/1ps

module tmr3_edge_tick #(
	parameter int DIV = 1
) (
	input  wire logic sys_clk,
	input  wire logic srst,
	input  wire logic async_in,
	output logic      tick
);

	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

	logic          sync_first;
	logic          sync_second;
	logic          prev_level;
	logic [CW-1:0] edge_count;
	logic          rise;

	// two-stage synchroniser; the first stage feeds nothing but the second
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sync_first  <= 1'b0;
			sync_second <= 1'b0;
			prev_level  <= 1'b0;
		end else begin
			sync_first  <= async_in;
			sync_second <= sync_first;
			prev_level  <= sync_second;
		end
	end

	assign rise = sync_second & ~prev_level;

	// one tick every DIV rising edges; source must be slower than sys_clk / 2
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			edge_count <= '0;
			tick       <= 1'b0;
		end else if (rise) begin
			if (edge_count == CW'(DIV - 1)) begin
				edge_count <= '0;
				tick       <= 1'b1;
			end else begin
				edge_count <= edge_count + CW'(1);
				tick       <= 1'b0;
			end
		end else begin
			tick <= 1'b0;
		end
	end

endmodule : tmr3_edge_tick

// *** tmr3_clk_mux.sv ***
// per-byte count tick selection between system clock and the alternate source
`timescale 1ns/1ps

module tmr3_clk_mux (
	input  wire logic       system_clock_sel,
	input  wire logic [1:0] alt_clock_sel,
	input  wire logic       tick_div12,
	input  wire logic       tick_rtc,
	input  wire logic       tick_ext8,
	output logic            tick
);

	// reserved alternate code gives no ticks unless system_clock_sel is set
	always_comb begin
		tick = 1'b0;
		if (system_clock_sel) begin
			tick = 1'b1;
		end else begin
			unique case (alt_clock_sel)
				tmr3_pkg::ALT_SYSTEM_CLOCK_DIV12: tick = tick_div12;
				tmr3_pkg::ALT_RTC:          tick = tick_rtc;
				tmr3_pkg::ALT_RESERVED:     tick = 1'b0;
				tmr3_pkg::ALT_EXT_DIV8:     tick = tick_ext8;
			endcase
		end
	end

endmodule : tmr3_clk_mux

// *** tmr3_reload_capture.sv ***
// timer three: 16-bit or split 8-bit auto-reload counter with oscillator capture
//
// Function
// - split bit picks 16-bit or two 8-bit
// - 16-bit rollover loads reload pair unless capture enabled, sets high flag
// - 16-bit overflow interrupts when timer interrupts enabled
// - low byte rollover interrupts if low enable set
// - four clocks; slow sources synchronised first
// - split bytes reload from own reload register
// - split run bit gates high byte only
// - system_clock bit or alternate select picks clock
// - split bytes set own overflow flags
// - split interrupts on high, or either byte
// - flags never cleared by hardware
// - capture enable selects capture, split kept zero
// - capture on rtc edge or every 8 ext
// - capture copies counter to reload, sets flag
// - control register resets to zero
`timescale 1ns/1ps

module tmr3_reload_capture (
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	input  wire logic       high_byte_system_clock_sel,
	input  wire logic       low_byte_system_clock_sel,
	input  wire logic       timer_irq_en,
	input  wire logic       rtc_clk_in,
	input  wire logic       ext_osc_in,
	output logic            irq_request
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] timer_three_control;
	logic [7:0] reload_low_byte;
	logic [7:0] reload_high_byte;
	logic [7:0] count_low_byte;
	logic [7:0] count_high_byte;
	logic [3:0] prescale_count;
	logic       tick_div12;
	logic       tick_rtc;
	logic       tick_ext8;
	logic       low_tick;
	logic       high_tick;
	logic [7:0] next_count_low;
	logic [7:0] next_count_high;
	logic       low_ovf;
	logic       high_ovf;
	logic       capture_event;
	logic [7:0] read_value;

	logic       high_overflow_flag;
	logic       low_overflow_flag;
	logic       low_overflow_irq_en;
	logic       capture_mode_en;
	logic       split_mode_sel;
	logic       high_run_control;
	logic [1:0] alt_clock_sel;
	logic       capture_source_sel;
	logic       wr_control;
	logic       wr_reload_low;
	logic       wr_reload_high;
	logic       wr_count_low;
	logic       wr_count_high;

	assign high_overflow_flag  = timer_three_control[tmr3_pkg::BIT_HIGH_FLAG];
	assign low_overflow_flag   = timer_three_control[tmr3_pkg::BIT_LOW_FLAG];
	assign low_overflow_irq_en = timer_three_control[tmr3_pkg::BIT_LOW_IRQ_EN];
	assign capture_mode_en     = timer_three_control[tmr3_pkg::BIT_CAPTURE_EN];
	assign split_mode_sel      = timer_three_control[tmr3_pkg::BIT_SPLIT];
	assign high_run_control    = timer_three_control[tmr3_pkg::BIT_RUN];
	assign alt_clock_sel       = timer_three_control[tmr3_pkg::BIT_ALT_SEL_HI:
	                                                 tmr3_pkg::BIT_ALT_SEL_LO];
	assign capture_source_sel  = timer_three_control[tmr3_pkg::BIT_ALT_SEL_HI];

	// ----------------------------------------------------------------
	// register bus decode
	// ----------------------------------------------------------------
	assign wr_control     = sfr_wr && (sfr_addr == tmr3_pkg::ADDR_CONTROL);
	assign wr_reload_low  = sfr_wr && (sfr_addr == tmr3_pkg::ADDR_RELOAD_LOW);
	assign wr_reload_high = sfr_wr && (sfr_addr == tmr3_pkg::ADDR_RELOAD_HIGH);
	assign wr_count_low   = sfr_wr && (sfr_addr == tmr3_pkg::ADDR_COUNT_LOW);
	assign wr_count_high  = sfr_wr && (sfr_addr == tmr3_pkg::ADDR_COUNT_HIGH);

	// ----------------------------------------------------------------
	// clock sources
	// ----------------------------------------------------------------

	// divide-by-12 prescaler on the system clock
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prescale_count <= 4'h0;
			tick_div12     <= 1'b0;
		end else if (prescale_count == 4'(tmr3_pkg::SYSTEM_CLOCK_DIV - 1)) begin
			prescale_count <= 4'h0;
			tick_div12     <= 1'b1;
		end else begin
			prescale_count <= prescale_count + 4'h1;
			tick_div12     <= 1'b0;
		end
	end

	// slow sources are synchronised before they can tick the counter
	tmr3_edge_tick #(.DIV(tmr3_pkg::RTC_DIV)) u_rtc_tick (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.async_in (rtc_clk_in),
		.tick     (tick_rtc)
	);

	tmr3_edge_tick #(.DIV(tmr3_pkg::EXT_DIV)) u_ext_tick (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.async_in (ext_osc_in),
		.tick     (tick_ext8)
	);

	// each byte has its own system_clock override; 16-bit mode uses the low selection
	tmr3_clk_mux u_low_mux (
		.system_clock_sel    (low_byte_system_clock_sel),
		.alt_clock_sel (alt_clock_sel),
		.tick_div12    (tick_div12),
		.tick_rtc      (tick_rtc),
		.tick_ext8     (tick_ext8),
		.tick          (low_tick)
	);

	tmr3_clk_mux u_high_mux (
		.system_clock_sel    (high_byte_system_clock_sel),
		.alt_clock_sel (alt_clock_sel),
		.tick_div12    (tick_div12),
		.tick_rtc      (tick_rtc),
		.tick_ext8     (tick_ext8),
		.tick          (high_tick)
	);

	// capture trigger: rtc edge or every eighth ext edge
	assign capture_event = capture_mode_en &&
	                       (capture_source_sel ? tick_ext8 : tick_rtc);

	// ----------------------------------------------------------------
	// counter next-state
	// ----------------------------------------------------------------

	// capture mode free-runs the 16-bit count, the reload pair holds captures
	always_comb begin
		next_count_low  = count_low_byte;
		next_count_high = count_high_byte;
		low_ovf         = 1'b0;
		high_ovf        = 1'b0;
		if (split_mode_sel) begin
			if (low_tick) begin
				low_ovf        = (count_low_byte == tmr3_pkg::BYTE_MAX);
				next_count_low = low_ovf ? reload_low_byte
				                         : count_low_byte + 8'h01;
			end
			if (high_run_control && high_tick) begin
				high_ovf        = (count_high_byte == tmr3_pkg::BYTE_MAX);
				next_count_high = high_ovf ? reload_high_byte
				                           : count_high_byte + 8'h01;
			end
		end else if (high_run_control && low_tick) begin
			low_ovf  = (count_low_byte == tmr3_pkg::BYTE_MAX);
			high_ovf = low_ovf && (count_high_byte == tmr3_pkg::BYTE_MAX);
			if (high_ovf && !capture_mode_en) begin
				next_count_low  = reload_low_byte;
				next_count_high = reload_high_byte;
			end else begin
				{next_count_high, next_count_low} =
					16'({count_high_byte, count_low_byte} + 16'h0001);
			end
		end
		// software writes win over counting
		if (wr_count_low) begin
			next_count_low = sfr_wdata;
		end
		if (wr_count_high) begin
			next_count_high = sfr_wdata;
		end
	end

	// counter bytes
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			count_low_byte  <= tmr3_pkg::BYTE_RESET;
			count_high_byte <= tmr3_pkg::BYTE_RESET;
		end else begin
			count_low_byte  <= next_count_low;
			count_high_byte <= next_count_high;
		end
	end

	// reload pair; a capture beats a same-cycle software write
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			reload_low_byte  <= tmr3_pkg::BYTE_RESET;
			reload_high_byte <= tmr3_pkg::BYTE_RESET;
		end else if (capture_event) begin
			reload_low_byte  <= count_low_byte;
			reload_high_byte <= count_high_byte;
		end else begin
			if (wr_reload_low) begin
				reload_low_byte <= sfr_wdata;
			end
			if (wr_reload_high) begin
				reload_high_byte <= sfr_wdata;
			end
		end
	end

	// control register; hardware flag sets win over a clearing write
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			timer_three_control <= tmr3_pkg::CONTROL_RESET;
		end else begin
			if (wr_control) begin
				timer_three_control <= sfr_wdata;
			end
			timer_three_control[tmr3_pkg::BIT_HIGH_FLAG] <=
				(wr_control ? sfr_wdata[tmr3_pkg::BIT_HIGH_FLAG] : high_overflow_flag)
				| high_ovf | capture_event;
			timer_three_control[tmr3_pkg::BIT_LOW_FLAG] <=
				(wr_control ? sfr_wdata[tmr3_pkg::BIT_LOW_FLAG] : low_overflow_flag)
				| low_ovf;
		end
	end

	// ----------------------------------------------------------------
	// interrupt request and read data
	// ----------------------------------------------------------------

	// level request held while an enabled flag stands
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq_request <= 1'b0;
		end else begin
			irq_request <= timer_irq_en && (high_overflow_flag ||
			               (low_overflow_irq_en && low_overflow_flag));
		end
	end

	// unmapped addresses read as zero
	always_comb begin
		case (sfr_addr)
			tmr3_pkg::ADDR_CONTROL:     read_value = timer_three_control;
			tmr3_pkg::ADDR_RELOAD_LOW:  read_value = reload_low_byte;
			tmr3_pkg::ADDR_RELOAD_HIGH: read_value = reload_high_byte;
			tmr3_pkg::ADDR_COUNT_LOW:   read_value = count_low_byte;
			tmr3_pkg::ADDR_COUNT_HIGH:  read_value = count_high_byte;
			default:                    read_value = tmr3_pkg::BYTE_ZERO;
		endcase
	end

	// read data registered one cycle after the strobe, held otherwise
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sfr_rdata <= tmr3_pkg::BYTE_ZERO;
		end else if (sfr_rd) begin
			sfr_rdata <= read_value;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	logic no_sw_write;
	assign no_sw_write = !sfr_wr;

	property p_full_rollover;
		@(posedge sys_clk) disable iff (srst)
		(!split_mode_sel && !capture_mode_en && high_run_control && low_tick &&
		 count_low_byte == 8'hFF && count_high_byte == 8'hFF && no_sw_write)
		|=> ({count_high_byte, count_low_byte} ==
		     $past({reload_high_byte, reload_low_byte})) && high_overflow_flag;
	endproperty
	a_full_rollover: assert property (p_full_rollover)
		else $error("16-bit rollover did not reload or flag");

	property p_irq_high;
		@(posedge sys_clk) disable iff (srst)
		(timer_irq_en && high_overflow_flag) |=> irq_request;
	endproperty
	a_irq_high: assert property (p_irq_high)
		else $error("high flag did not raise interrupt");

	property p_irq_low;
		@(posedge sys_clk) disable iff (srst)
		(timer_irq_en && low_overflow_irq_en && low_overflow_flag) |=> irq_request;
	endproperty
	a_irq_low: assert property (p_irq_low)
		else $error("low flag with enable did not raise interrupt");

	property p_irq_low_masked;
		@(posedge sys_clk) disable iff (srst)
		(!high_overflow_flag && !low_overflow_irq_en) |=> !irq_request;
	endproperty
	a_irq_low_masked: assert property (p_irq_low_masked)
		else $error("interrupt raised without an enabled source");

	property p_split_low_reload;
		@(posedge sys_clk) disable iff (srst)
		(split_mode_sel && low_tick && count_low_byte == 8'hFF && no_sw_write)
		|=> count_low_byte == $past(reload_low_byte) && low_overflow_flag;
	endproperty
	a_split_low_reload: assert property (p_split_low_reload)
		else $error("split low byte did not reload and flag");

	property p_split_high_stopped;
		@(posedge sys_clk) disable iff (srst)
		(split_mode_sel && !high_run_control && no_sw_write) |=> $stable(count_high_byte);
	endproperty
	a_split_high_stopped: assert property (p_split_high_stopped)
		else $error("stopped high byte moved in split mode");

	property p_flag_sticky;
		@(posedge sys_clk) disable iff (srst)
		(high_overflow_flag && low_overflow_flag && no_sw_write)
		|=> high_overflow_flag && low_overflow_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("overflow flag cleared by hardware");

	property p_capture;
		@(posedge sys_clk) disable iff (srst)
		capture_event |=> ({reload_high_byte, reload_low_byte} ==
		                   $past({count_high_byte, count_low_byte})) && high_overflow_flag;
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture did not copy counter");

	property p_reset_control;
		@(posedge sys_clk) srst |=> timer_three_control == 8'h00;
	endproperty
	a_reset_control: assert property (p_reset_control)
		else $error("control register not zero after reset");

	property p_reserved_clock;
		@(posedge sys_clk) disable iff (srst)
		(!low_byte_system_clock_sel && alt_clock_sel == 2'h2) |-> !low_tick;
	endproperty
	a_reserved_clock: assert property (p_reserved_clock)
		else $error("reserved clock code produced a tick");

	property p_prescale_gap;
		@(posedge sys_clk) disable iff (srst)
		tick_div12 |=> !tick_div12 [*8];
	endproperty
	a_prescale_gap: assert property (p_prescale_gap)
		else $error("divide-by-12 tick too frequent");

endmodule : tmr3_reload_capture

// *** tmr3_cpu_model.sv ***
// processor-side model that drives the register bus and enables of timer three
`timescale 1ns/1ps

module tmr3_cpu_model (
	input  wire logic       sys_clk,
	input  wire logic [7:0] sfr_rdata,
	output logic      [7:0] sfr_addr,
	output logic            sfr_wr,
	output logic            sfr_rd,
	output logic      [7:0] sfr_wdata,
	output logic            high_byte_system_clock_sel,
	output logic            low_byte_system_clock_sel,
	output logic            timer_irq_en
);
	// ----------------------------------------------------------------
	// idle bus
	// ----------------------------------------------------------------
	// quiet bus at time zero, address parked on a non-register value
	initial begin
		sfr_addr = 8'hA5;
		sfr_wdata = 8'h5A;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		high_byte_system_clock_sel = 1'b0;
		low_byte_system_clock_sel = 1'b0;
		timer_irq_en = 1'b0;
	end

	// ----------------------------------------------------------------
	// bus cycles, entered one step after a rising edge
	// ----------------------------------------------------------------
	// released lines show the inverse, so stale values are never trusted
	task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
		sfr_addr = addr;
		sfr_wdata = data;
		sfr_wr = 1'b1;
		@(posedge sys_clk) #1;
		sfr_wr = 1'b0;
		sfr_addr = ~addr;
		sfr_wdata = ~data;
		@(posedge sys_clk) #1;
	endtask : sfr_write

	// read data is registered, so it is taken one edge after the strobe
	task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
		sfr_addr = addr;
		sfr_rd = 1'b1;
		@(posedge sys_clk) #1;
		sfr_rd = 1'b0;
		sfr_addr = ~addr;
		@(posedge sys_clk) #1;
		data = sfr_rdata;
	endtask : sfr_read

	// clock choices and interrupt enable held in other core registers
	task automatic set_env(input logic hs, input logic ls, input logic ie);
		high_byte_system_clock_sel = hs;
		low_byte_system_clock_sel = ls;
		timer_irq_en = ie;
	endtask : set_env

	// acknowledge: flags are written to zero, other fields taken from ctrl
	task automatic ack_flags(input logic [7:0] ctrl);
		sfr_write(tmr3_pkg::ADDR_CONTROL, ctrl & 8'h3F);
	endtask : ack_flags

	// one capture pair read, both flags seen in one control read
	task automatic read_pair(output logic [15:0] val, output logic [7:0] ctrl);
		sfr_read(tmr3_pkg::ADDR_CONTROL, ctrl);
		sfr_read(tmr3_pkg::ADDR_RELOAD_LOW, val[7:0]);
		sfr_read(tmr3_pkg::ADDR_RELOAD_HIGH, val[15:8]);
	endtask : read_pair

endmodule : tmr3_cpu_model

// *** timer3_reload_capture_tb.sv ***
// self-checking bench for the timer three reload and capture block
`timescale 1ns/1ps

module timer3_reload_capture_tb;
	logic       sys_clk = 1'b0;
	logic       srst = 1'b1;
	logic       rtc_clk_in = 1'b0;
	logic       ext_osc_in = 1'b0;
	logic [7:0] sfr_addr;
	logic       sfr_wr;
	logic       sfr_rd;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic       high_byte_system_clock_sel;
	logic       low_byte_system_clock_sel;
	logic       timer_irq_en;
	logic       irq_request;
	int         fails = 0;
	int         samples_checked = 0;

	// ----------------------------------------------------------------
	// clocks: rtc period 10 cycles, external oscillator 4 cycles
	// ----------------------------------------------------------------
	// oscillator edges land on falling system edges, keeping sync latency fixed
	always #12.5 sys_clk = ~sys_clk;
	always #125 rtc_clk_in = ~rtc_clk_in;
	always #50 ext_osc_in = ~ext_osc_in;

	tmr3_reload_capture DUT (
		.sys_clk(sys_clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.high_byte_system_clock_sel(high_byte_system_clock_sel), .low_byte_system_clock_sel(low_byte_system_clock_sel),
		.timer_irq_en(timer_irq_en), .rtc_clk_in(rtc_clk_in), .ext_osc_in(ext_osc_in),
		.irq_request(irq_request)
	);

	tmr3_cpu_model cpu (
		.sys_clk(sys_clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .high_byte_system_clock_sel(high_byte_system_clock_sel),
		.low_byte_system_clock_sel(low_byte_system_clock_sel), .timer_irq_en(timer_irq_en)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check

	// counts that depend on free-running oscillators get a small tolerance
	task automatic near(input string what, input logic [8:0] exp, input logic [7:0] got,
			input logic [8:0] tol);
		samples_checked++;
		if ($isunknown(got) || {1'b0, got} + tol < exp || {1'b0, got} > exp + tol) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : near

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk) #1;
	endtask : cyc

	task automatic wait_irq(input logic exp, input int maxc);
		for (int i = 0; i < maxc && irq_request !== exp; i++) cyc(1);
		check("irq_request", {15'h0000, exp}, {15'h0000, irq_request});
	endtask : wait_irq

	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		logic [7:0] d;
		for (int a = 8'h91; a <= 8'h96; a++) begin
			cpu.sfr_read(a[7:0], d);
			check("reset value", 16'h0000, d);
		end
		cpu.sfr_write(8'h96, 8'hFF);
		cpu.sfr_read(8'h96, d);
		check("unmapped", 16'h0000, d);
		// reserved alternate clock keeps the split low byte still here
		cpu.sfr_write(tmr3_pkg::ADDR_CONTROL, 8'h2A);
		cpu.sfr_read(tmr3_pkg::ADDR_CONTROL, d);
		check("control rw", 16'h002A, d);
		cpu.sfr_write(tmr3_pkg::ADDR_CONTROL, 8'h00);
		$display("test reset done");
	endtask : t_reset

	task automatic t_mode16;
		logic [7:0] d;
		cpu.set_env(1'b0, 1'b1, 1'b1);
		cpu.sfr_write(tmr3_pkg::ADDR_RELOAD_LOW, 8'h34);
		cpu.sfr_write(tmr3_pkg::ADDR_RELOAD_HIGH, 8'h12);
		cpu.sfr_write(tmr3_pkg::ADDR_COUNT_LOW, 8'hFE);
		cpu.sfr_write(tmr3_pkg::ADDR_COUNT_HIGH, 8'hFF);
		cpu.sfr_write(tmr3_pkg::ADDR_CONTROL, 8'h04);
		wait_irq(1'b1, 20);
		cyc(5);
		cpu.sfr_read(tmr3_pkg::ADDR_CONTROL, d);
		check("control", 16'h00C4, d);
		cpu.ack_flags(8'h00);
		wait_irq(1'b0, 3);
		cpu.sfr_read(tmr3_pkg::ADDR_COUNT_HIGH, d);
		check("count high", 16'h0012, d);
		$display("test mode16 done");
	endtask : t_mode16

	task automatic t_low_irq;
		logic [7:0] d;
		for (int en = 0; en < 2; en++) begin
			cpu.sfr_write(tmr3_pkg::ADDR_COUNT_HIGH, 8'h00);
			cpu.sfr_write(tmr3_pkg::ADDR_COUNT_LOW, 8'hFE);
			cpu.sfr_write(tmr3_pkg::ADDR_CONTROL, 8'h04 | (en[7:0] << 5));
			cyc(8);
			check("low irq", en[15:0], {15'h0000, irq_request});
			cpu.sfr_read(tmr3_pkg::ADDR_CONTROL, d);
			check("control", 16'h0044 | (en[15:0] << 5), d);
			cpu.ack_flags(8'h00);
		end
		$display("test low_irq done");
	endtask : t_low_irq

	task automatic t_split;
		logic [7:0] d;
		cpu.set_env(1'b1, 1'b1, 1'b1);
		cpu.sfr_write(tmr3_pkg::ADDR_RELOAD_LOW, 8'hF0);
		cpu.sfr_write(tmr3_pkg::ADDR_RELOAD_HIGH, 8'h80);
		cpu.sfr_write(tmr3_pkg::ADDR_COUNT_LOW, 8'hFE);
		cpu.sfr_write(tmr3_pkg::ADDR_COUNT_HIGH, 8'hFE);
		cpu.sfr_write(tmr3_pkg::ADDR_CONTROL, 8'h08);
		cyc(6);
		cpu.sfr_read(tmr3_pkg::ADDR_COUNT_HIGH, d);
		check("stopped high", 16'h00FE, d);
		cpu.sfr_read(tmr3_pkg::ADDR_CONTROL, d);
		check("control", 16'h0048, d);
		check("irq low only", 16'h0000, {15'h0000, irq_request});
		cpu.sfr_write(tmr3_pkg::ADDR_CONTROL, 8'h0C);
		wait_irq(1'b1, 8);
		cpu.sfr_read(tmr3_pkg::ADDR_CONTROL, d);
		check("high flag", 16'h0080, d & 8'h80);
		cpu.sfr_read(tmr3_pkg::ADDR_COUNT_HIGH, d);
		near("high reload", 9'h084, d, 9'h004);
		cpu.sfr_read(tmr3_pkg::ADDR_COUNT_LOW, d);
		near("low reload", 9'h0F8, d, 9'h008);
		cpu.ack_flags(8'h00);
		$display("test split done");
	endtask : t_split

	task automatic t_clock_sel;
		logic [7:0] d;
		logic [8:0] exp [4] = '{9'd10, 9'd12, 9'd0, 9'd4};
		cpu.set_env(1'b0, 1'b0, 1'b0);
		for (int alt = 0; alt < 4; alt++) begin
			cpu.sfr_write(tmr3_pkg::ADDR_COUNT_LOW, 8'h00);
			cpu.sfr_write(tmr3_pkg::ADDR_COUNT_HIGH, 8'h00);
			cpu.sfr_write(tmr3_pkg::ADDR_CONTROL, 8'h0C | alt[7:0]);
			cyc(120);
			cpu.sfr_read(tmr3_pkg::ADDR_COUNT_LOW, d);
			near("low ticks", exp[alt], d, {8'h00, alt != 2});
			cpu.sfr_read(tmr3_pkg::ADDR_COUNT_HIGH, d);
			near("high ticks", exp[alt], d, {8'h00, alt != 2});
			cpu.sfr_write(tmr3_pkg::ADDR_CONTROL, 8'h00);
		end
		$display("test clock_sel done");
	endtask : t_clock_sel

	task automatic t_capture;
		logic [15:0] c1;
		logic [15:0] c2;
		logic [7:0]  d;
		logic [7:0]  ctl;
		cpu.set_env(1'b0, 1'b1, 1'b1);
		for (int src = 0; src < 2; src++) begin
			// split stays zero so the full counter is captured
			ctl = 8'h14 | (src[7:0] << 1);
			cpu.sfr_write(tmr3_pkg::ADDR_CONTROL, ctl);
			wait_irq(1'b1, 80);
			cpu.read_pair(c1, d);
			check("capture flag", 16'h0080, d & 8'h80);
			cpu.ack_flags(ctl);
			wait_irq(1'b1, 80);
			cpu.read_pair(c2, d);
			// successive captures differ by the trigger period in timer clocks: one rtc period or eight ext periods
			check("capture period", src ? 16'd32 : 16'd10, c2 - c1);
			cpu.ack_flags(8'h00);
		end
		$display("test capture done");
	endtask : t_capture

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge sys_clk);
		#1 srst = 1'b0;
		t_reset();
		t_mode16();
		t_low_irq();
		t_split();
		t_clock_sel();
		t_capture();
		end_of_test();
	end

	// generous bound: all tests need about 800 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		end_of_test();
	end

endmodule : timer3_reload_capture_tb
